// ---- bench/pdsc_host_model.sv ----
// pdsc_host_model: host side of the byte-wide register port.
// assumes the bench calls its tasks; drives on the falling edge.
`timescale 1ns/1ps
module pdsc_host_model
  import pdsc_pkg::*;
(
  // clock
  input  wire logic       ref_clk_i,
  // register port
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_idx_o,
  output logic      [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_idx_o   = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // one byte per access; strobe held across one rising edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    @(negedge ref_clk_i);
    reg_idx_o   = idx;
    reg_wdata_o = dat;
    reg_wr_o    = 1'b1;
    @(negedge ref_clk_i);
    reg_wr_o    = 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] dat);
    @(negedge ref_clk_i);
    reg_idx_o = idx;
    reg_rd_o  = 1'b1;
    @(negedge ref_clk_i);
    reg_rd_o  = 1'b0;
    dat       = reg_rdata_i;
  endtask
  // top and height first, nonzero step last
  task automatic scroll(input logic [7:0] top, input logic [7:0] hgt,
                        input logic [7:0] step);
    wr(PDSC_IDX_SCR_TOP, top);
    wr(PDSC_IDX_SCR_HGT, hgt);
    wr(PDSC_IDX_SCR_STEP, step);
  endtask
  // window values clipped to the visible range
  task automatic win(input logic [7:0] idx, input logic [7:0] val);
    wr(idx, (val > 8'hAF) ? 8'hAF : val);
  endtask
endmodule // pdsc_host_model

// ---- bench/pdsc_partial_scroll_bench.sv ----
// pdsc_partial_scroll_bench: register and line checks of the block.
// assumes a 25 MHz clock and the host model for register traffic.
`timescale 1ns/1ps
module pdsc_partial_scroll_bench;
  import pdsc_pkg::*;
  logic       clk;
  logic       rst_n;
  logic       wr;
  logic       rd;
  logic [7:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       req;
  logic [7:0] y;
  logic       valid;
  pdsc_line_t line;
  logic       pmode;
  logic       sact;
  logic [7:0] col = 8'h5A;
  logic       ce = 1'b1;
  int         error_cnt = 0;
  int         check_count = 0;
  int         cycles = 0;
  logic [7:0] idx_tab [8] = '{PDSC_IDX_SCR_TOP, PDSC_IDX_SCR_HGT,
    PDSC_IDX_SCR_STEP, PDSC_IDX_OFF_COL, PDSC_IDX_W1_START,
    PDSC_IDX_W2_START, PDSC_IDX_W1_CNT, PDSC_IDX_W2_CNT};

  pdsc_host_model host (.ref_clk_i(clk), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_idx_o(idx), .reg_wdata_o(wdata), .reg_rdata_i(rdata));
  pdsc_partial_scroll #(.NUM_LINES(PDSC_LINES)) dut (.ref_clk_i(clk),
    .rst_n_i(rst_n), .ce_i(ce), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_idx_i(idx), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .line_req_i(req), .line_y_i(y), .line_valid_o(valid),
    .line_o(line), .partial_mode_o(pmode), .scroll_active_o(sact));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      results();
    end
  end

  task automatic chk_reg(string nm, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(string nm, logic e, logic g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic chk_line(string nm, pdsc_line_t e, pdsc_line_t g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rd_chk(logic [7:0] i, logic [7:0] e);
    logic [7:0] v;
    host.rd(i, v);
    chk_reg($sformatf("reg %h", i), e, v);
  endtask
  // one request; answer seen one edge later, gone the edge after
  task automatic ln(logic [7:0] yy, logic b, logic [7:0] a);
    @(negedge clk);
    req = 1'b1;
    y   = yy;
    @(negedge clk);
    req = 1'b0;
    chk_bit("valid", 1'b1, valid);
    chk_line($sformatf("line %h", yy), '{b, a, col}, line);
    @(negedge clk);
    chk_bit("valid low", 1'b0, valid);
  endtask
  task automatic done(string nm);
    $display("test %s done", nm);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    req   = 1'b0;
    y     = 8'h00;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    foreach (idx_tab[i]) rd_chk(idx_tab[i], PDSC_REG_RST);
    rd_chk(8'h12, PDSC_ZERO);
    foreach (idx_tab[i]) begin
      host.wr(idx_tab[i], idx_tab[i] + 8'h30);
      rd_chk(idx_tab[i], idx_tab[i] + 8'h30);
    end
    host.wr(PDSC_IDX_W1_CNT, 8'h00);
    host.wr(PDSC_IDX_W2_CNT, 8'h00);
    host.wr(PDSC_IDX_OFF_COL, col);
    done("registers");
    host.scroll(8'h2C, 8'h57, 8'h01);
    chk_bit("scroll on", 1'b1, sact);
    ln(8'h2C, 1'b0, 8'h2D);
    ln(8'h83, 1'b0, 8'h2C);
    ln(8'h2B, 1'b0, 8'h2B);
    ln(8'h84, 1'b0, 8'h84);
    host.wr(PDSC_IDX_SCR_STEP, 8'h57);
    ln(8'h2C, 1'b0, 8'h83);
    host.wr(PDSC_IDX_SCR_STEP, 8'h58);
    chk_bit("scroll on", 1'b0, sact);
    ln(8'h2C, 1'b0, 8'h2C);
    host.scroll(8'h58, 8'h57, 8'h02);
    ln(8'hAF, 1'b0, 8'h59);
    host.scroll(8'h59, 8'h57, 8'h02);
    chk_bit("scroll on", 1'b0, sact);
    ln(8'h5A, 1'b0, 8'h5A);
    host.scroll(8'h00, 8'hAF, 8'hAF);
    ln(8'h01, 1'b0, 8'h00);
    host.wr(PDSC_IDX_SCR_STEP, 8'h00);
    chk_bit("scroll on", 1'b0, sact);
    ln(8'h01, 1'b0, 8'h01);
    done("scroll");
    host.scroll(8'h2C, 8'h57, 8'h01);
    host.win(PDSC_IDX_W1_START, 8'h10);
    host.win(PDSC_IDX_W1_CNT, 8'h01);
    chk_bit("partial", 1'b1, pmode);
    chk_bit("scroll on", 1'b0, sact);
    ln(8'h10, 1'b1, 8'h10);
    ln(8'h11, 1'b0, 8'h11);
    ln(8'h0F, 1'b0, 8'h0F);
    ln(8'h2C, 1'b0, 8'h2C);
    host.wr(PDSC_IDX_SCR_STEP, 8'h03);
    rd_chk(PDSC_IDX_SCR_STEP, 8'h01);
    host.win(PDSC_IDX_W2_START, 8'h20);
    host.win(PDSC_IDX_W2_CNT, 8'h02);
    ln(8'h21, 1'b1, 8'h21);
    ln(8'h22, 1'b0, 8'h22);
    host.win(PDSC_IDX_W1_CNT, 8'h10);
    ln(8'h1F, 1'b1, 8'h1F);
    ln(8'h20, 1'b0, 8'h20);
    host.win(PDSC_IDX_W2_START, 8'h10);
    host.win(PDSC_IDX_W2_CNT, 8'h20);
    ln(8'h25, 1'b0, 8'h25);
    host.win(PDSC_IDX_W1_CNT, 8'h00);
    chk_bit("partial", 1'b0, pmode);
    chk_bit("scroll on", 1'b1, sact);
    ln(8'h21, 1'b0, 8'h21);
    ln(8'h2C, 1'b0, 8'h2D);
    done("partial");
    // a write while the enable is low must leave the colour alone
    ce = 1'b0;
    host.wr(PDSC_IDX_OFF_COL, 8'hA5);
    ce = 1'b1;
    rd_chk(PDSC_IDX_OFF_COL, col);
    chk_bit("scroll on", 1'b1, sact);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk_bit("partial", 1'b0, pmode);
    chk_bit("scroll on", 1'b0, sact);
    rd_chk(PDSC_IDX_SCR_STEP, PDSC_REG_RST);
    done("enable and reset");
    results();
  end
endmodule // pdsc_partial_scroll_bench

// ---- rtl/pdsc_line_map.sv ----
// pdsc_line_map: per-line decision, one registered stage: blank with
// the partial-off colour or fetch a RAM line, scrolled or not.
// assumes the enables arrive already checked for validity.
`timescale 1ns/1ps
module pdsc_line_map
  import pdsc_pkg::*;
(
  // clock, reset, enable
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  // configuration
  input  wire pdsc_cfg_t  cfg_i,
  input  wire logic       w1_on_i,
  input  wire logic       w2_on_i,
  input  wire logic       scroll_on_i,
  // line request
  input  wire logic       req_i,
  input  wire logic [7:0] y_i,
  // line answer
  output logic            valid_o,
  output pdsc_line_t      line_o
);

  typedef struct packed {
    logic       valid;
    pdsc_line_t line;
  } pdsc_map_state_t;

  pdsc_map_state_t q, d;

  always_comb begin
    logic       in1;
    logic       in2;
    logic [7:0] off;
    logic [8:0] off2;
    logic [8:0] band;
    in1  = 1'b0;
    in2  = 1'b0;
    off  = 8'h00;
    off2 = 9'h000;
    band = {1'b0, cfg_i.scr_hgt} + 9'h001;
    d = q;
    d.valid = req_i;
    if (req_i) begin
      in1 = w1_on_i && pdsc_in_span(y_i, cfg_i.w1_start,
                                    {1'b0, cfg_i.w1_cnt});
      in2 = w2_on_i && pdsc_in_span(y_i, cfg_i.w2_start,
                                    {1'b0, cfg_i.w2_cnt});
      d.line.blank  = in1 || in2;
      d.line.colour = cfg_i.off_colour;
      d.line.addr   = y_i;
      if (scroll_on_i &&
          pdsc_in_span(y_i, cfg_i.scr_top, band)) begin
        off  = y_i - cfg_i.scr_top;
        off2 = {1'b0, off} + {1'b0, cfg_i.scr_step};
        // step never exceeds height, so one subtraction wraps
        if (off2 >= band) begin
          off2 = off2 - band;
        end
        d.line.addr = cfg_i.scr_top + off2[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign valid_o = q.valid;
  assign line_o  = q.line;

  property p_one_line;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && req_i && w1_on_i && cfg_i.w1_cnt == 8'h01 &&
      y_i == cfg_i.w1_start |=> line_o.blank;
  endproperty
  a_one_line: assert property (p_one_line)
    else $error("one-line window not blanked");

  property p_no_scroll_addr;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && req_i && !scroll_on_i |=> line_o.addr == $past(y_i);
  endproperty
  a_no_scroll_addr: assert property (p_no_scroll_addr)
    else $error("address moved without scrolling");

  property p_band_top;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && req_i && scroll_on_i && y_i == cfg_i.scr_top |=>
      line_o.addr == $past(cfg_i.scr_top) + $past(cfg_i.scr_step);
  endproperty
  a_band_top: assert property (p_band_top)
    else $error("band top line not shifted by step");

  property p_colour;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && req_i |=> valid_o && line_o.colour == $past(cfg_i.off_colour);
  endproperty
  a_colour: assert property (p_colour)
    else $error("blank colour not taken from register");

endmodule // pdsc_line_map

// ---- rtl/pdsc_partial_scroll.sv ----
// pdsc_partial_scroll: register file for partial windows and vertical
// scroll, validity checks, and the per-line address/blank decision.
// assumes host register writes and line requests are synchronous to
// ref_clk_i; a request is answered one enabled edge later.
`timescale 1ns/1ps
module pdsc_partial_scroll
  import pdsc_pkg::*;
#(
  parameter int unsigned NUM_LINES = PDSC_LINES
) (
  // clock, reset, enable
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  // register port
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_idx_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // line request and answer
  input  wire logic       line_req_i,
  input  wire logic [7:0] line_y_i,
  output logic            line_valid_o,
  output pdsc_line_t      line_o,
  // status
  output logic            partial_mode_o,
  output logic            scroll_active_o
);

  if (NUM_LINES < 2 || NUM_LINES > 256) begin : g_chk
    $error("NUM_LINES must lie in 2..256");
  end

  localparam logic [8:0] LINES_W9 = 9'(NUM_LINES);

  typedef struct packed {
    pdsc_cfg_t  cfg;
    logic [7:0] rdata;
    logic       partial;
    logic       scroll;
  } pdsc_state_t;

  pdsc_state_t q, d;
  logic        w1_on;
  logic        w2_on;
  logic        scroll_on;

  // partial mode is defined by a nonzero first window count
  function automatic logic f_partial(pdsc_cfg_t c);
    return c.w1_cnt != PDSC_ZERO;
  endfunction

  function automatic logic f_win2_ok(pdsc_cfg_t c);
    logic [8:0] e1;
    logic [8:0] e2;
    e1 = {1'b0, c.w1_start} + {1'b0, c.w1_cnt};
    e2 = {1'b0, c.w2_start} + {1'b0, c.w2_cnt};
    // at least one free line between the two windows
    return f_partial(c) && (c.w2_cnt != PDSC_ZERO) &&
           (({1'b0, c.w2_start} > e1) ||
            ({1'b0, c.w1_start} > e2));
  endfunction

  function automatic logic f_scroll_ok(pdsc_cfg_t c);
    logic [8:0] sum;
    sum = {1'b0, c.scr_top} + {1'b0, c.scr_hgt};
    return !f_partial(c) &&
           (c.scr_step != PDSC_ZERO) &&
           (sum < LINES_W9) &&
           (c.scr_step <= c.scr_hgt);
  endfunction

  always_comb begin
    d = q;
    if (reg_wr_i) begin
      if (reg_idx_i == PDSC_IDX_SCR_TOP) begin
        d.cfg.scr_top = reg_wdata_i;
      end else if (reg_idx_i == PDSC_IDX_SCR_HGT) begin
        d.cfg.scr_hgt = reg_wdata_i;
      end else if (reg_idx_i == PDSC_IDX_SCR_STEP) begin
        // a step written in partial mode is dropped, not held back
        if (!f_partial(q.cfg)) begin
          d.cfg.scr_step = reg_wdata_i;
        end
      end else if (reg_idx_i == PDSC_IDX_OFF_COL) begin
        d.cfg.off_colour = reg_wdata_i;
      end else if (reg_idx_i == PDSC_IDX_W1_START) begin
        d.cfg.w1_start = reg_wdata_i;
      end else if (reg_idx_i == PDSC_IDX_W2_START) begin
        d.cfg.w2_start = reg_wdata_i;
      end else if (reg_idx_i == PDSC_IDX_W1_CNT) begin
        d.cfg.w1_cnt = reg_wdata_i;
      end else if (reg_idx_i == PDSC_IDX_W2_CNT) begin
        d.cfg.w2_cnt = reg_wdata_i;
      end
    end
    if (reg_rd_i) begin
      if (reg_idx_i == PDSC_IDX_SCR_TOP) begin
        d.rdata = q.cfg.scr_top;
      end else if (reg_idx_i == PDSC_IDX_SCR_HGT) begin
        d.rdata = q.cfg.scr_hgt;
      end else if (reg_idx_i == PDSC_IDX_SCR_STEP) begin
        d.rdata = q.cfg.scr_step;
      end else if (reg_idx_i == PDSC_IDX_OFF_COL) begin
        d.rdata = q.cfg.off_colour;
      end else if (reg_idx_i == PDSC_IDX_W1_START) begin
        d.rdata = q.cfg.w1_start;
      end else if (reg_idx_i == PDSC_IDX_W2_START) begin
        d.rdata = q.cfg.w2_start;
      end else if (reg_idx_i == PDSC_IDX_W1_CNT) begin
        d.rdata = q.cfg.w1_cnt;
      end else if (reg_idx_i == PDSC_IDX_W2_CNT) begin
        d.rdata = q.cfg.w2_cnt;
      end else begin
        d.rdata = PDSC_ZERO;
      end
    end
    // status follows the new settings on the same edge as they land
    d.partial = f_partial(d.cfg);
    d.scroll  = f_scroll_ok(d.cfg);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      q <= '{cfg: '{default: PDSC_REG_RST}, rdata: PDSC_ZERO,
             partial: 1'b0, scroll: 1'b0};
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign w1_on     = f_partial(q.cfg);
  assign w2_on     = f_win2_ok(q.cfg);
  assign scroll_on = f_scroll_ok(q.cfg);

  pdsc_line_map u_map (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .cfg_i       (q.cfg),
    .w1_on_i     (w1_on),
    .w2_on_i     (w2_on),
    .scroll_on_i (scroll_on),
    .req_i       (line_req_i),
    .y_i         (line_y_i),
    .valid_o     (line_valid_o),
    .line_o      (line_o)
  );

  assign reg_rdata_o     = q.rdata;
  assign partial_mode_o  = q.partial;
  assign scroll_active_o = q.scroll;

  property p_step_ignored;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && reg_wr_i && reg_idx_i == PDSC_IDX_SCR_STEP && partial_mode_o
      |=> $stable(q.cfg.scr_step);
  endproperty
  a_step_ignored: assert property (p_step_ignored)
    else $error("step write taken in partial mode");

  property p_step_zero_stops;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && reg_wr_i && reg_idx_i == PDSC_IDX_SCR_STEP &&
      reg_wdata_i == 8'h00 && !partial_mode_o |=> !scroll_active_o;
  endproperty
  a_step_zero_stops: assert property (p_step_zero_stops)
    else $error("scroll still active after zero step");

  property p_sum_limit;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    scroll_active_o |->
      ({1'b0, q.cfg.scr_top} + {1'b0, q.cfg.scr_hgt}) < LINES_W9;
  endproperty
  a_sum_limit: assert property (p_sum_limit)
    else $error("scroll active with band past last line");

  property p_step_le_hgt;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    scroll_active_o |-> q.cfg.scr_step <= q.cfg.scr_hgt &&
                        q.cfg.scr_step != 8'h00;
  endproperty
  a_step_le_hgt: assert property (p_step_le_hgt)
    else $error("scroll active with invalid step");

  property p_partial_no_scroll;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    partial_mode_o |-> !scroll_active_o;
  endproperty
  a_partial_no_scroll: assert property (p_partial_no_scroll)
    else $error("scroll active in partial mode");

  property p_no_window;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && line_req_i && q.cfg.w1_cnt == 8'h00 |=> !line_o.blank;
  endproperty
  a_no_window: assert property (p_no_window)
    else $error("line blanked with first count zero");

  property p_top_store;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && reg_wr_i && reg_idx_i == PDSC_IDX_SCR_TOP |=>
      q.cfg.scr_top == $past(reg_wdata_i);
  endproperty
  a_top_store: assert property (p_top_store)
    else $error("top line write not stored");

  property p_overlap_drop;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && line_req_i && partial_mode_o &&
      q.cfg.w2_start == q.cfg.w1_start &&
      !pdsc_in_span(line_y_i, q.cfg.w1_start, {1'b0, q.cfg.w1_cnt})
      |=> !line_o.blank;
  endproperty
  a_overlap_drop: assert property (p_overlap_drop)
    else $error("overlapping second window applied");

  property p_win1_blank;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && line_req_i && partial_mode_o &&
      pdsc_in_span(line_y_i, q.cfg.w1_start, {1'b0, q.cfg.w1_cnt})
      |=> line_o.blank;
  endproperty
  a_win1_blank: assert property (p_win1_blank)
    else $error("line inside first window not blanked");

endmodule // pdsc_partial_scroll

// ---- rtl/pdsc_pkg.sv ----
// pdsc_pkg: constants, register indices and carrier types for the
// partial-window and scroll line addressing block.
// assumes one 25 MHz clock, synchronous active-low reset, byte-wide
// register writes addressed by register index.
// Operation
// - window start and height come from registers
// - window lines show partial-off colour, not RAM
// - window count is a direct line count
// - count zero means no window
// - second window needs nonzero first count
// - overlapping or touching windows drop the second
// - partial mode disables scroll, ignores step writes
// - scroll band from top, height, step registers
// - top line field is direct Y address
// - height field means value plus one lines
// - step is lines shifted, zero means none
// - step write of zero stops scroll at once
// - top plus height reaching 176 disables scroll
// - step above height disables scroll
package pdsc_pkg;

  // display geometry
  localparam int unsigned PDSC_LINES = 176;

  // register indices
  localparam logic [7:0] PDSC_IDX_SCR_TOP  = 8'h0F;
  localparam logic [7:0] PDSC_IDX_SCR_HGT  = 8'h10;
  localparam logic [7:0] PDSC_IDX_SCR_STEP = 8'h11;
  localparam logic [7:0] PDSC_IDX_OFF_COL  = 8'h13;
  localparam logic [7:0] PDSC_IDX_W1_START = 8'h14;
  localparam logic [7:0] PDSC_IDX_W2_START = 8'h15;
  localparam logic [7:0] PDSC_IDX_W1_CNT   = 8'h16;
  localparam logic [7:0] PDSC_IDX_W2_CNT   = 8'h17;

  // reset value of every register, and of unmapped reads
  localparam logic [7:0] PDSC_REG_RST = 8'h00;
  localparam logic [7:0] PDSC_ZERO    = 8'h00;

  typedef struct packed {
    logic [7:0] scr_top;
    logic [7:0] scr_hgt;
    logic [7:0] scr_step;
    logic [7:0] off_colour;
    logic [7:0] w1_start;
    logic [7:0] w2_start;
    logic [7:0] w1_cnt;
    logic [7:0] w2_cnt;
  } pdsc_cfg_t;

  typedef struct packed {
    logic       blank;
    logic [7:0] addr;
    logic [7:0] colour;
  } pdsc_line_t;

  // true when y lies in [start, start+len)
  function automatic logic pdsc_in_span(logic [7:0] y, logic [7:0] start,
                                        logic [8:0] len);
    logic [8:0] stop;
    stop = {1'b0, start} + len;
    return (y >= start) && ({1'b0, y} < stop);
  endfunction

endpackage
